//--- logic/gpc_port.sv
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
module gpc_port
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Register port
    input  wire logic [4:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Peripheral sources for the matrix
    input  wire logic [7:0]  periph_a_data,
    input  wire logic [7:0]  periph_b_data,
    // Power state
    input  wire logic        deep_pd,
    // Pads
    input  wire logic [7:0]  pad_in,
    output logic      [7:0]  pad_out,
    output logic      [7:0]  pad_oe,
    output logic      [7:0]  pad_pu,
    output logic      [7:0]  pad_pd,
    output logic      [7:0]  pad_ie,
    output logic      [7:0]  pad_analog,
    output logic             pad_low_voltage_ttl_threshold,
    output logic             pad_slew_slow,
    // Port interrupt request
    output logic             irq
);

    localparam int unsigned N = gpc_pkg::PINS;

    logic [N-1:0]   out_r, out_nxt;
    logic [23:0]    mode_r, mode_nxt;
    logic [N-1:0]   ien_r, ien_nxt;
    logic [15:0]    edge_r, edge_nxt;
    logic [N-1:0]   stat_r, stat_nxt;
    logic [2:0]     cfg_r, cfg_nxt;
    logic [15:0]    fsel_r, fsel_nxt;
    logic [N-1:0]   in_r, in_nxt;
    logic [N-1:0]   prev_r, prev_nxt;
    logic [31:0]    rdata_r, rdata_nxt;
    logic [N-1:0]   evt;
    logic [N-1:0]   clr;
    logic [N-1:0]   d_out, d_oe, d_pu, d_pd, d_ie, d_an;
    logic [N-1:0]   out_q, oe_q, pu_q, pd_q, ie_q, an_q;
    logic [N-1:0]   out_d, oe_d, pu_d, pd_d, ie_d, an_d;
    logic           hold_act;

    //////////////////////////////////////////////////////////////////////////
    // Register file

    always_comb
    begin
        out_nxt   = out_r;
        mode_nxt  = mode_r;
        ien_nxt   = ien_r;
        edge_nxt  = edge_r;
        cfg_nxt   = cfg_r;
        fsel_nxt  = fsel_r;
        clr       = '0;
        rdata_nxt = 32'h0000_0000;
        if (reg_wr)
        begin
            case (reg_addr)
                gpc_pkg::OFS_OUT:  out_nxt  = reg_wdata[7:0];
                gpc_pkg::OFS_MODE: mode_nxt = reg_wdata[23:0];
                gpc_pkg::OFS_IEN:  ien_nxt  = reg_wdata[7:0];
                gpc_pkg::OFS_EDGE: edge_nxt = reg_wdata[15:0];
                gpc_pkg::OFS_STAT: clr      = reg_wdata[7:0];
                gpc_pkg::OFS_CFG:  cfg_nxt  = reg_wdata[2:0];
                gpc_pkg::OFS_FSEL: fsel_nxt = reg_wdata[15:0];
                default:           clr      = '0;
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                gpc_pkg::OFS_OUT:  rdata_nxt = {24'h000000, out_r};
                gpc_pkg::OFS_IN:   rdata_nxt = {24'h000000, in_r};
                gpc_pkg::OFS_MODE: rdata_nxt = {8'h00, mode_r};
                gpc_pkg::OFS_IEN:  rdata_nxt = {24'h000000, ien_r};
                gpc_pkg::OFS_EDGE: rdata_nxt = {16'h0000, edge_r};
                gpc_pkg::OFS_STAT: rdata_nxt = {24'h000000, stat_r};
                gpc_pkg::OFS_CFG:  rdata_nxt = {29'h00000000, cfg_r};
                gpc_pkg::OFS_FSEL: rdata_nxt = {16'h0000, fsel_r};
                default:           rdata_nxt = 32'h0000_0000;
            endcase
        end
        stat_nxt = (stat_r & ~clr) | evt;
        // sample pins with input buffer on
        in_nxt   = pad_in & ie_q;
        prev_nxt = in_r;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            out_r   <= gpc_pkg::RST_OUT;
            mode_r  <= gpc_pkg::RST_MODE;
            ien_r   <= gpc_pkg::RST_IEN;
            edge_r  <= gpc_pkg::RST_EDGE;
            stat_r  <= gpc_pkg::RST_STAT;
            cfg_r   <= gpc_pkg::RST_CFG;
            fsel_r  <= gpc_pkg::RST_FSEL;
            in_r    <= '0;
            prev_r  <= '0;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            out_r   <= out_nxt;
            mode_r  <= mode_nxt;
            ien_r   <= ien_nxt;
            edge_r  <= edge_nxt;
            stat_r  <= stat_nxt;
            cfg_r   <= cfg_nxt;
            fsel_r  <= fsel_nxt;
            in_r    <= in_nxt;
            prev_r  <= prev_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    //////////////////////////////////////////////////////////////////////////
    // Per-pin matrix, drive and edge detect

    // one slice per pin of the port
    generate
        for (genvar i = 0; i < N; i++)
        begin : g_slice
            gpc_pin_if pif ();
            logic [1:0] fsel;
            logic [1:0] esel;

            assign fsel = fsel_r[2*i +: 2];
            assign esel = edge_r[2*i +: 2];

            always_comb
            begin
                case (gpc_pkg::gpc_fn_t'(fsel))
                    gpc_pkg::GPC_FN_PORT:     pif.data = out_r[i];
                    gpc_pkg::GPC_FN_PERIPH_A: pif.data = periph_a_data[i];
                    gpc_pkg::GPC_FN_PERIPH_B: pif.data = periph_b_data[i];
                    default:                  pif.data = 1'b0;
                endcase
                d_an[i]  = (fsel == gpc_pkg::GPC_FN_ANALOG);
                pif.mode = d_an[i] ? gpc_pkg::GPC_ANALOG : mode_r[3*i +: 3];
            end

            gpc_pin_drv u_drv
            (
                .pin (pif.drv)
            );

            assign d_out[i] = pif.out;
            assign d_oe[i]  = pif.oe;
            assign d_pu[i]  = pif.pu;
            assign d_pd[i]  = pif.pd;
            assign d_ie[i]  = pif.ie;

            always_comb
            begin
                case (gpc_pkg::gpc_edge_t'(esel))
                    gpc_pkg::GPC_EDGE_RISE: evt[i] = in_r[i] & ~prev_r[i];
                    gpc_pkg::GPC_EDGE_FALL: evt[i] = ~in_r[i] & prev_r[i];
                    gpc_pkg::GPC_EDGE_BOTH: evt[i] = in_r[i] ^ prev_r[i];
                    default:                evt[i] = 1'b0;
                endcase
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // Pad registers and hold

    assign hold_act = deep_pd & cfg_r[gpc_pkg::CFG_HOLD];

    always_comb
    begin
        if (hold_act)
        begin
            out_d = out_q;
            oe_d  = oe_q;
            pu_d  = pu_q;
            pd_d  = pd_q;
            ie_d  = ie_q;
            an_d  = an_q;
        end
        else
        begin
            out_d = d_out;
            oe_d  = d_oe;
            pu_d  = d_pu;
            pd_d  = d_pd;
            ie_d  = d_ie;
            an_d  = d_an;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            out_q <= '0;
            oe_q  <= '0;
            pu_q  <= '0;
            pd_q  <= '0;
            ie_q  <= '0;
            an_q  <= '0;
        end
        else
        begin
            out_q <= out_d;
            oe_q  <= oe_d;
            pu_q  <= pu_d;
            pd_q  <= pd_d;
            ie_q  <= ie_d;
            an_q  <= an_d;
        end
    end

    assign pad_out    = out_q;
    assign pad_oe     = oe_q;
    assign pad_pu     = pu_q;
    assign pad_pd     = pd_q;
    assign pad_ie     = ie_q;
    assign pad_analog = an_q;

    assign pad_low_voltage_ttl_threshold = cfg_r[gpc_pkg::CFG_THRESH];
    assign pad_slew_slow = cfg_r[gpc_pkg::CFG_SLOW];

    // enabled flags merge to one request
    assign irq = |(stat_r & ien_r);

    //////////////////////////////////////////////////////////////////////////
    // Assertions

    reset_analog_a : assert property (@(posedge clk_sys) rst |=> (pad_oe == 8'h00) && (pad_ie == 8'h00)
        && (pad_pu == 8'h00) && (pad_pd == 8'h00))
        else $error("pins not analog after reset");

    out_readback_a : assert property (@(posedge clk_sys) disable iff (rst)
        reg_wr && reg_addr == gpc_pkg::OFS_OUT ##1 reg_rd && reg_addr == gpc_pkg::OFS_OUT
        |=> reg_rdata[7:0] == $past(reg_wdata[7:0], 2))
        else $error("output value readback wrong");

    in_sample_a : assert property (@(posedge clk_sys) disable iff (rst)
        pad_ie[0] |=> in_r[0] == $past(pad_in[0]))
        else $error("input state not sampled");

    irq_merge_a : assert property (@(posedge clk_sys) disable iff (rst)
        evt[0] && ien_r[0] && !$past(rst) |=> irq)
        else $error("enabled event gave no request");

    strong_drive_a : assert property (@(posedge clk_sys) disable iff (rst)
        !hold_act && mode_r[2:0] == gpc_pkg::GPC_STRONG && fsel_r[1:0] == gpc_pkg::GPC_FN_PORT
        |=> pad_oe[0] && pad_out[0] == $past(out_r[0]))
        else $error("strong mode not driving stored value");

    od_low_a : assert property (@(posedge clk_sys) disable iff (rst)
        !hold_act && mode_r[2:0] == gpc_pkg::GPC_OD_LOW && fsel_r[1:0] == gpc_pkg::GPC_FN_PORT && out_r[0]
        |=> !pad_oe[0])
        else $error("open drain low drove a one");

    hold_keep_a : assert property (@(posedge clk_sys) disable iff (rst)
        hold_act ##1 hold_act |-> $stable(pad_oe) && $stable(pad_out) && $stable(pad_pu))
        else $error("pad changed while held");

    thresh_sel_a : assert property (@(posedge clk_sys) disable iff (rst)
        reg_wr && reg_addr == gpc_pkg::OFS_CFG
        |=> pad_low_voltage_ttl_threshold == $past(reg_wdata[gpc_pkg::CFG_THRESH]))
        else $error("threshold select not applied");

    slew_sel_a : assert property (@(posedge clk_sys) disable iff (rst)
        reg_wr && reg_addr == gpc_pkg::OFS_CFG |=> pad_slew_slow == $past(reg_wdata[gpc_pkg::CFG_SLOW]))
        else $error("slew select not applied");

    matrix_analog_a : assert property (@(posedge clk_sys) disable iff (rst)
        !hold_act && fsel_r[1:0] == gpc_pkg::GPC_FN_ANALOG |=> pad_analog[0] && !pad_oe[0] && !pad_ie[0])
        else $error("analog selection left buffers on");

    flag_set_wins_a : assert property (@(posedge clk_sys) disable iff (rst)
        evt[0] && reg_wr && reg_addr == gpc_pkg::OFS_STAT && reg_wdata[0] |=> stat_r[0])
        else $error("event lost against clear");

endmodule

//--- logic/gpc_pkg.sv
package gpc_pkg;

    // Port geometry
    localparam int unsigned PINS      = 8;
    localparam int unsigned MODE_W    = 3;
    localparam int unsigned SEL_W     = 2;
    localparam int unsigned ADDR_W    = 5;
    localparam int unsigned DATA_W    = 32;

    // Register byte offsets
    localparam logic [4:0] OFS_OUT    = 5'h00;
    localparam logic [4:0] OFS_IN     = 5'h04;
    localparam logic [4:0] OFS_MODE   = 5'h08;
    localparam logic [4:0] OFS_IEN    = 5'h0c;
    localparam logic [4:0] OFS_EDGE   = 5'h10;
    localparam logic [4:0] OFS_STAT   = 5'h14;
    localparam logic [4:0] OFS_CFG    = 5'h18;
    localparam logic [4:0] OFS_FSEL   = 5'h1c;

    // Port configuration fields
    localparam int unsigned CFG_THRESH = 0;
    localparam int unsigned CFG_SLOW  = 1;
    localparam int unsigned CFG_HOLD  = 2;
    localparam int unsigned CFG_W     = 3;

    // Reset values
    localparam logic [7:0]  RST_OUT   = 8'h00;
    localparam logic [23:0] RST_MODE  = 24'h000000;
    localparam logic [7:0]  RST_IEN   = 8'h00;
    localparam logic [15:0] RST_EDGE  = 16'h0000;
    localparam logic [7:0]  RST_STAT  = 8'h00;
    localparam logic [2:0]  RST_CFG   = 3'h0;
    localparam logic [15:0] RST_FSEL  = 16'h0000;

    // Drive modes, in hardware encoding order
    typedef enum logic [2:0] {
        GPC_ANALOG,
        GPC_INPUT,
        GPC_WPU_SPD,
        GPC_SPU_WPD,
        GPC_OD_LOW,
        GPC_OD_HIGH,
        GPC_STRONG,
        GPC_WEAK
    } gpc_mode_t;

    // Interrupt edge selection
    typedef enum logic [1:0] {
        GPC_EDGE_OFF,
        GPC_EDGE_RISE,
        GPC_EDGE_FALL,
        GPC_EDGE_BOTH
    } gpc_edge_t;

    // Pin function matrix sources
    typedef enum logic [1:0] {
        GPC_FN_PORT,
        GPC_FN_PERIPH_A,
        GPC_FN_PERIPH_B,
        GPC_FN_ANALOG
    } gpc_fn_t;

endpackage

//--- logic/gpc_pin_if.sv
`timescale 1ns/10ps
interface gpc_pin_if;
    logic [2:0] mode;
    logic       data;
    logic       out;
    logic       oe;
    logic       pu;
    logic       pd;
    logic       ie;

    modport ctl (output mode, output data, input out, input oe, input pu, input pd, input ie);
    modport drv (input mode, input data, output out, output oe, output pu, output pd, output ie);
endinterface

//--- logic/gpc_pin_drv.sv
`timescale 1ns/10ps
module gpc_pin_drv
(
    // Pin control
    gpc_pin_if.drv pin
);

    always_comb
    begin
        pin.out = pin.data;
        pin.oe  = 1'b0;
        pin.pu  = 1'b0;
        pin.pd  = 1'b0;
        pin.ie  = 1'b1;
        case (gpc_pkg::gpc_mode_t'(pin.mode))
            gpc_pkg::GPC_ANALOG:
            begin
                pin.ie = 1'b0;
            end
            gpc_pkg::GPC_INPUT:
            begin
                pin.ie = 1'b1;
            end
            gpc_pkg::GPC_WPU_SPD:
            begin
                pin.pu = pin.data;
                pin.oe = ~pin.data;
            end
            gpc_pkg::GPC_SPU_WPD:
            begin
                pin.oe = pin.data;
                pin.pd = ~pin.data;
            end
            gpc_pkg::GPC_OD_LOW:
            begin
                pin.oe = ~pin.data;
            end
            gpc_pkg::GPC_OD_HIGH:
            begin
                pin.oe = pin.data;
            end
            gpc_pkg::GPC_STRONG:
            begin
                pin.oe = 1'b1;
            end
            gpc_pkg::GPC_WEAK:
            begin
                pin.pu = pin.data;
                pin.pd = ~pin.data;
            end
            default:
            begin
                pin.ie = 1'b0;
            end
        endcase
    end

endmodule

//--- tb/gpc_pad_model.sv
`timescale 1ns/10ps
module gpc_pad_model
(
    // Clock
    input  wire logic       clk_sys,
    // Device side of the pads
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pad_pu,
    input  wire logic [7:0] pad_pd,
    // Board side drivers
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    // Resolved pad level
    output logic      [7:0] pad_in
);
    logic [7:0] float_r = 8'h00;

    // A pin nobody drives or pulls wanders, so it never holds its last value
    always_ff @(posedge clk_sys)
    begin
        float_r <= ~pad_in;
    end

    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pad_oe[i])
                pad_in[i] = pad_out[i];
            else if (ext_en[i])
                pad_in[i] = ext_val[i];
            else if (pad_pu[i])
                pad_in[i] = 1'b1;
            else if (pad_pd[i])
                pad_in[i] = 1'b0;
            else
                pad_in[i] = float_r[i];
        end
    end
endmodule

//--- tb/test_gpio_port_control.sv
`timescale 1ns/10ps
module test_gpio_port_control;
    logic        clk_sys;
    logic        rst;
    logic [4:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [7:0]  periph_a_data;
    logic [7:0]  periph_b_data;
    logic        deep_pd;
    logic [7:0]  pad_in;
    logic [7:0]  pad_out;
    logic [7:0]  pad_oe;
    logic [7:0]  pad_pu;
    logic [7:0]  pad_pd;
    logic [7:0]  pad_ie;
    logic [7:0]  pad_analog;
    logic        pad_low_voltage_ttl_threshold;
    logic        pad_slew_slow;
    logic        irq;
    logic [7:0]  ext_en;
    logic [7:0]  ext_val;
    int          mismatches;
    int          check_count;
    int          cycles;

    gpc_port i_gpc_port (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_a_data(periph_a_data),
        .periph_b_data(periph_b_data), .deep_pd(deep_pd), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd), .pad_ie(pad_ie), .pad_analog(pad_analog),
        .pad_low_voltage_ttl_threshold(pad_low_voltage_ttl_threshold), .pad_slew_slow(pad_slew_slow),
        .irq(irq));

    gpc_pad_model i_gpc_pad_model (.clk_sys(clk_sys), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu),
        .pad_pd(pad_pd), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        if (mismatches == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    // Write then read with no gap between the strobes
    task automatic wr_rd(input logic [4:0] a, input logic [31:0] d, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge clk_sys);
        reg_rd    <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Pad controls {oe, pu, pd, ie} expected for one pin
    function automatic logic [3:0] drv_exp(input logic [2:0] m, input logic d);
        case (m)
            3'h0: drv_exp = 4'h0;
            3'h1: drv_exp = 4'h1;
            3'h2: drv_exp = {~d, d, 1'b0, 1'b1};
            3'h3: drv_exp = {d, 1'b0, ~d, 1'b1};
            3'h4: drv_exp = {~d, 3'b001};
            3'h5: drv_exp = {d, 3'b001};
            3'h6: drv_exp = 4'h9;
            default: drv_exp = {1'b0, d, ~d, 1'b1};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles >= 5000)
        begin
            mismatches = mismatches + 1;
            end_sim();
        end
    end

    initial
    begin
        logic [7:0] e_oe;
        logic [7:0] e_pu;
        logic [7:0] e_pd;
        logic [7:0] e_ie;
        logic [3:0] e;
        mismatches    = 0;
        check_count   = 0;
        cycles        = 0;
        rst           = 1'b1;
        reg_addr      = 5'h00;
        reg_wdata     = 32'h0;
        reg_wr        = 1'b0;
        reg_rd        = 1'b0;
        periph_a_data = 8'h3c;
        periph_b_data = 8'hc3;
        deep_pd       = 1'b0;
        ext_en        = 8'h00;
        ext_val       = 8'h00;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check({pad_oe, pad_ie, pad_pu, pad_pd}, 32'h0);
        check({24'h0, pad_analog}, 32'h0);
        for (int a = 0; a < 8; a++)
            rd(5'(a * 4), 32'h0);
        wr_rd(gpc_pkg::OFS_IN, 32'hff, 32'h0);
        // Strong drive of written data
        wr(gpc_pkg::OFS_MODE, {8'h0, {8{3'h6}}});
        wr(gpc_pkg::OFS_OUT, 32'ha5);
        settle(2);
        check({24'h0, pad_out}, 32'ha5);
        check({24'h0, pad_oe}, 32'hff);
        rd(gpc_pkg::OFS_OUT, 32'ha5);
        wr_rd(gpc_pkg::OFS_OUT, 32'h5a, 32'h5a);
        rd(5'h02, 32'h0);
        // Every drive mode against data 0x0f
        wr(gpc_pkg::OFS_OUT, 32'h0f);
        for (int m = 0; m < 8; m++)
        begin
            wr(gpc_pkg::OFS_MODE, {8'h0, {8{3'(m)}}});
            settle(2);
            for (int i = 0; i < 8; i++)
            begin
                e = drv_exp(3'(m), i < 4);
                {e_oe[i], e_pu[i], e_pd[i], e_ie[i]} = e;
            end
            check({pad_oe, pad_pu, pad_pd, pad_ie}, {e_oe, e_pu, e_pd, e_ie});
        end
        // Input capture, read-only input register
        ext_en  <= 8'hff;
        ext_val <= 8'h3c;
        wr(gpc_pkg::OFS_MODE, {8'h0, {8{3'h1}}});
        wr(gpc_pkg::OFS_IN, 32'hff);
        settle(3);
        rd(gpc_pkg::OFS_IN, 32'h3c);
        // Pin 0 rising, pin 1 falling edge flags
        ext_val <= 8'h00;
        wr(gpc_pkg::OFS_EDGE, 32'h0009);
        wr(gpc_pkg::OFS_STAT, 32'hff);
        ext_val <= 8'h03;
        settle(3);
        rd(gpc_pkg::OFS_STAT, 32'h01);
        check({31'h0, irq}, 32'h0);
        ext_val <= 8'h00;
        settle(3);
        rd(gpc_pkg::OFS_STAT, 32'h03);
        wr(gpc_pkg::OFS_IEN, 32'h02);
        settle(1);
        check({31'h0, irq}, 32'h1);
        wr(gpc_pkg::OFS_STAT, 32'h02);
        settle(1);
        check({31'h0, irq}, 32'h0);
        rd(gpc_pkg::OFS_STAT, 32'h01);
        // Event meets its own clear, then both-edge selection
        wr(gpc_pkg::OFS_EDGE, 32'h000b);
        wr(gpc_pkg::OFS_STAT, 32'hff);
        wr(gpc_pkg::OFS_IEN, 32'h01);
        ext_val <= 8'h01;
        wr(gpc_pkg::OFS_STAT, 32'h01);
        settle(1);
        check({31'h0, irq}, 32'h1);
        rd(gpc_pkg::OFS_STAT, 32'h01);
        wr(gpc_pkg::OFS_STAT, 32'h01);
        ext_val <= 8'h00;
        settle(3);
        rd(gpc_pkg::OFS_STAT, 32'h01);
        // Threshold and slew to the pads
        wr(gpc_pkg::OFS_CFG, 32'h3);
        settle(2);
        check({30'h0, pad_low_voltage_ttl_threshold, pad_slew_slow}, 32'h3);
        rd(gpc_pkg::OFS_CFG, 32'h3);
        wr(gpc_pkg::OFS_CFG, 32'h0);
        settle(2);
        check({30'h0, pad_low_voltage_ttl_threshold, pad_slew_slow}, 32'h0);
        // Hold freezes pads in deep power-down
        ext_en <= 8'h00;
        wr(gpc_pkg::OFS_MODE, {8'h0, {8{3'h6}}});
        wr(gpc_pkg::OFS_OUT, 32'ha5);
        wr(gpc_pkg::OFS_CFG, 32'h4);
        deep_pd <= 1'b1;
        wr(gpc_pkg::OFS_OUT, 32'h5a);
        settle(2);
        check({24'h0, pad_out}, 32'ha5);
        deep_pd <= 1'b0;
        settle(2);
        check({24'h0, pad_out}, 32'h5a);
        // Function matrix sources
        wr(gpc_pkg::OFS_FSEL, 32'h5555);
        settle(2);
        check({24'h0, pad_out}, 32'h3c);
        wr(gpc_pkg::OFS_FSEL, 32'haaaa);
        settle(2);
        check({24'h0, pad_out}, 32'hc3);
        wr(gpc_pkg::OFS_FSEL, 32'hffff);
        settle(2);
        check({16'h0, pad_analog, pad_oe}, 32'hff00);
        end_sim();
    end
endmodule
